// ### eic_pkg.sv
`default_nettype none
package eic_pkg;
  localparam int INSTR_W = 14;
  localparam int PC_W = 15;
  localparam int DATA_W = 8;
  localparam int FADDR_W = 7;
  localparam int PTR_W = 16;
  localparam int STACK_DEPTH_DEF = 16;
  localparam int Q_PHASES = 4;
  localparam logic [1:0] Q_LAST = 2'(Q_PHASES - 1);
  localparam int APB_AW = 8;

  // Word field positions
  localparam int CLS_HI = 13;
  localparam int CLS_LO = 12;
  localparam int OP_HI = 11;
  localparam int OP_LO = 8;
  localparam int BOP_HI = 11;
  localparam int BOP_LO = 10;
  localparam int B_HI = 9;
  localparam int B_LO = 7;
  localparam int D_POS = 7;
  localparam int JMP_SEL = 11;
  localparam int K11_HI = 10;
  localparam int N_POS = 2;
  localparam int PMEM_BIT = 15;

  typedef enum logic [2:0] {
    CLS_BYTE = 3'b001,
    CLS_BIT = 3'b010,
    CLS_LIT = 3'b100
  } eic_class_e;

  typedef enum logic [2:0] {
    ST_EXEC = 3'b001,
    ST_PMEM = 3'b010,
    ST_FLUSH = 3'b100
  } eic_state_e;

  // Byte-class operations, also the ALU operation codes
  localparam logic [3:0] OP_MOVWF = 4'h0;
  localparam logic [3:0] OP_CLR = 4'h1;
  localparam logic [3:0] OP_SUB = 4'h2;
  localparam logic [3:0] OP_DEC = 4'h3;
  localparam logic [3:0] OP_IOR = 4'h4;
  localparam logic [3:0] OP_AND = 4'h5;
  localparam logic [3:0] OP_XOR = 4'h6;
  localparam logic [3:0] OP_ADD = 4'h7;
  localparam logic [3:0] OP_MOVF = 4'h8;
  localparam logic [3:0] OP_COM = 4'h9;
  localparam logic [3:0] OP_INC = 4'ha;
  localparam logic [3:0] OP_DECSZ = 4'hb;
  localparam logic [3:0] OP_RRF = 4'hc;
  localparam logic [3:0] OP_RLF = 4'hd;
  localparam logic [3:0] OP_SWAP = 4'he;
  localparam logic [3:0] OP_INCSZ = 4'hf;

  // Bit-class operations
  localparam logic [1:0] BOP_CLEAR = 2'h0;
  localparam logic [1:0] BOP_SET = 2'h1;
  localparam logic [1:0] BOP_SKIP_CLR = 2'h2;
  localparam logic [1:0] BOP_SKIP_SET = 2'h3;

  // Literal/control operations
  localparam logic [3:0] LIT_LOADW = 4'h0;
  localparam logic [3:0] LIT_ADDW = 4'h1;
  localparam logic [3:0] LIT_ANDW = 4'h2;
  localparam logic [3:0] LIT_XORW = 4'h3;
  localparam logic [3:0] LIT_EXIT = 4'h4;
  localparam logic [3:0] LIT_RELJMP = 4'h5;
  localparam logic [3:0] LIT_PTR_RD = 4'h6;
  localparam logic [3:0] LIT_PTR_WR = 4'h7;
  localparam logic [3:0] LIT_RETURN = 4'h8;
  localparam logic [3:0] LIT_IEXIT = 4'h9;
  localparam logic [3:0] LIT_ACCJMP = 4'ha;
  localparam logic [3:0] LIT_ACCCALL = 4'hb;
  localparam logic [3:0] LIT_SLEEP = 4'hc;
  localparam logic [3:0] LIT_WDTCLR = 4'hd;

  // Pointer update modes
  localparam logic [1:0] MM_PRE_INC = 2'h0;
  localparam logic [1:0] MM_PRE_DEC = 2'h1;
  localparam logic [1:0] MM_POST_INC = 2'h2;
  localparam logic [1:0] MM_POST_DEC = 2'h3;

  // Special file addresses
  localparam logic [6:0] FA_IND0 = 7'h00;
  localparam logic [6:0] FA_IND1 = 7'h01;
  localparam logic [6:0] FA_STATUS = 7'h03;
  localparam logic [6:0] FA_PTR0_LO = 7'h04;
  localparam logic [6:0] FA_PTR0_HI = 7'h05;
  localparam logic [6:0] FA_PTR1_LO = 7'h06;
  localparam logic [6:0] FA_PTR1_HI = 7'h07;
  localparam logic [6:0] FA_WREG = 7'h09;

  // Status byte bit positions
  localparam int ST_C = 0;
  localparam int ST_DC = 1;
  localparam int ST_Z = 2;
  localparam int ST_SLEEP = 3;
  localparam int ST_WDT = 4;

  // APB map
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_STATUS = 8'h04;
  localparam logic [7:0] A_WREG = 8'h08;
  localparam logic [7:0] A_PC = 8'h0c;
  localparam logic [7:0] A_IR = 8'h10;
  localparam logic [7:0] A_CYCLES = 8'h14;
  localparam logic [7:0] A_RETIRED = 8'h18;
  localparam logic [7:0] A_READS = 8'h1c;
  localparam int CTRL_RUN = 0;
  localparam int CTRL_GIE = 1;
  localparam int STAT_Q_LO = 8;
  localparam int STAT_ST_LO = 16;
  localparam int PC_SP_LO = 16;
endpackage : eic_pkg
`default_nettype wire

// ### eic_alu.sv
`default_nettype none
module eic_alu import eic_pkg::*; (
  // Operation and operands
  input wire logic [3:0] op,
  input wire logic [7:0] a,
  input wire logic [7:0] w,
  input wire logic c_in,
  // Result and flags
  output logic [7:0] y,
  output logic c_out,
  output logic dc_out,
  output logic upd_c,
  output logic upd_dc,
  output logic upd_z
);
  logic [8:0] sum;
  logic [4:0] nib;

  always_comb begin
    sum = 9'h000;
    nib = 5'h00;
    y = a;
    c_out = c_in;
    dc_out = 1'b0;
    upd_c = 1'b0;
    upd_dc = 1'b0;
    upd_z = 1'b1;
    unique case (op)
      OP_MOVWF: begin
        y = w;
        upd_z = 1'b0;
      end
      OP_CLR: y = 8'h00;
      OP_SUB, OP_ADD: begin
        // Subtract is add of the complement plus one, so carry means no borrow
        sum = (op == OP_SUB) ? ({1'b0, a} + {1'b0, ~w} + 9'h001) : ({1'b0, a} + {1'b0, w});
        nib = (op == OP_SUB) ? ({1'b0, a[3:0]} + {1'b0, ~w[3:0]} + 5'h01)
                             : ({1'b0, a[3:0]} + {1'b0, w[3:0]});
        y = sum[7:0];
        c_out = sum[8];
        dc_out = nib[4];
        upd_c = 1'b1;
        upd_dc = 1'b1;
      end
      OP_DEC: y = a - 8'h01;
      OP_IOR: y = a | w;
      OP_AND: y = a & w;
      OP_XOR: y = a ^ w;
      OP_MOVF: y = a;
      OP_COM: y = ~a;
      OP_INC: y = a + 8'h01;
      OP_DECSZ: begin
        y = a - 8'h01;
        upd_z = 1'b0;
      end
      OP_RRF: begin
        y = {c_in, a[7:1]};
        c_out = a[0];
        upd_c = 1'b1;
        upd_z = 1'b0;
      end
      OP_RLF: begin
        y = {a[6:0], c_in};
        c_out = a[7];
        upd_c = 1'b1;
        upd_z = 1'b0;
      end
      OP_SWAP: begin
        y = {a[3:0], a[7:4]};
        upd_z = 1'b0;
      end
      OP_INCSZ: begin
        y = a + 8'h01;
        upd_z = 1'b0;
      end
    endcase
  end
endmodule // eic_alu
`default_nettype wire

// ### eic_ptr.sv
`default_nettype none
module eic_ptr import eic_pkg::*; #(
  parameter int PW = PTR_W
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Byte loads from file writes
  input wire logic ld_lo,
  input wire logic ld_hi,
  input wire logic [7:0] wdata,
  // Auto update
  input wire logic step,
  input wire logic [1:0] mode,
  // Pointer value and address used by the access
  output logic [PW-1:0] ptr_reg,
  output logic [PW-1:0] eff
);
  logic [PW-1:0] upd;
  logic post;

  always_comb begin
    upd = ((mode == MM_PRE_DEC) || (mode == MM_POST_DEC)) ? ptr_reg - PW'(1)
                                                         : ptr_reg + PW'(1);
    post = (mode == MM_POST_INC) || (mode == MM_POST_DEC);
    eff = post ? ptr_reg : upd;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ptr_reg <= '0;
    end else if (ld_lo) begin
      ptr_reg[7:0] <= wdata;
    end else if (ld_hi) begin
      ptr_reg[PW-1:8] <= wdata[PW-9:0];
    end else if (step) begin
      ptr_reg <= upd;
    end
  end
endmodule // eic_ptr
`default_nettype wire

// ### eic_core.sv
`default_nettype none
module eic_core import eic_pkg::*; #(
  parameter int STACK_DEPTH = STACK_DEPTH_DEF
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Program memory
  output logic [PC_W-1:0] pmem_addr,
  input wire logic [INSTR_W-1:0] pmem_rdata
);
  localparam int SPW = $clog2(STACK_DEPTH);

  eic_state_e state_reg;
  logic [1:0] q_reg;
  logic run_reg, gie_reg, c_reg, dc_reg, z_reg, sleep_reg, wdt_reg;
  logic [7:0] w_reg;
  logic [PC_W-1:0] pc_reg;
  logic [INSTR_W-1:0] ir_reg, last_ir_reg;
  logic [SPW-1:0] sp_reg;
  logic [PC_W-1:0] stack [STACK_DEPTH];
  logic [7:0] mem [2**FADDR_W];
  logic [31:0] cyc_cnt_reg, ret_cnt_reg, rd_cnt_reg;

  logic cyc_end, exec, lit, ctl, ind, ptr_op, to_pmem, sel_n, dsel, bit_val;
  logic wr_f, wr_w, two, skip, push, pop, ptr_step, set_gie, do_sleep, do_wdt;
  logic [INSTR_W-1:0] cur;
  eic_class_e cls;
  logic [3:0] op;
  logic [1:0] bop, mm;
  logic [2:0] bpos;
  logic [6:0] fa, tgt;
  logic [7:0] k8, fval, f_new, w_new, bmask, status_byte, alu_a, alu_y;
  logic [3:0] alu_op;
  logic [PC_W-1:0] pc_n, pc_inc;
  logic [PTR_W-1:0] ia;
  logic [PTR_W-1:0] p_val [2];
  logic [PTR_W-1:0] p_eff [2];
  logic alu_c, alu_dc, upd_c, upd_dc, upd_z, alu_used;

  // Instruction cycle phase counter; wraps naturally at four phases
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_reg <= 2'h0;
    end else if (run_reg) begin
      q_reg <= q_reg + 2'h1;
    end
  end
  assign cyc_end = run_reg && (q_reg == Q_LAST);

  // Decode; fields not used by an operation are never looked at, except op, whose bits set the ALU flags of bit operations
  always_comb begin
    cur = (state_reg == ST_PMEM) ? ir_reg : pmem_rdata;
    if (cur[CLS_HI]) begin
      cls = CLS_LIT;
    end else if (cur[CLS_LO]) begin
      cls = CLS_BIT;
    end else begin
      cls = CLS_BYTE;
    end
    lit = (cls == CLS_LIT);
    ctl = lit && cur[CLS_LO];
    op = cur[OP_HI:OP_LO];
    bop = cur[BOP_HI:BOP_LO];
    bpos = cur[B_HI:B_LO];
    dsel = cur[D_POS];
    fa = cur[FADDR_W-1:0];
    k8 = cur[7:0];
    mm = cur[1:0];
    ptr_op = ctl && ((op == LIT_PTR_RD) || (op == LIT_PTR_WR));
    ind = !lit && ((fa == FA_IND0) || (fa == FA_IND1));
    sel_n = ptr_op ? cur[N_POS] : fa[0];
    ia = ptr_op ? p_eff[sel_n] : p_val[sel_n];
    to_pmem = (ind || ptr_op) && ia[PMEM_BIT];
    tgt = (ind || ptr_op) ? ia[FADDR_W-1:0] : fa;
    bmask = 8'h01 << bpos;
  end

  // Read half of every file access, including write-only operations
  always_comb begin
    status_byte = 8'h00;
    status_byte[ST_C] = c_reg;
    status_byte[ST_DC] = dc_reg;
    status_byte[ST_Z] = z_reg;
    status_byte[ST_SLEEP] = sleep_reg;
    status_byte[ST_WDT] = wdt_reg;
    if (to_pmem) begin
      fval = pmem_rdata[7:0];
    end else begin
      unique case (tgt)
        FA_IND0, FA_IND1: fval = 8'h00;
        FA_STATUS: fval = status_byte;
        FA_PTR0_LO: fval = p_val[0][7:0];
        FA_PTR0_HI: fval = p_val[0][PTR_W-1:8];
        FA_PTR1_LO: fval = p_val[1][7:0];
        FA_PTR1_HI: fval = p_val[1][PTR_W-1:8];
        FA_WREG: fval = w_reg;
        default: fval = mem[tgt];
      endcase
    end
    bit_val = fval[bpos];
    alu_used = !lit || (ctl && ((op == LIT_ADDW) || (op == LIT_ANDW) || (op == LIT_XORW)));
    alu_a = lit ? k8 : fval;
    if (!lit) begin
      alu_op = op;
    end else if (op == LIT_ADDW) begin
      alu_op = OP_ADD;
    end else if (op == LIT_ANDW) begin
      alu_op = OP_AND;
    end else begin
      alu_op = OP_XOR;
    end
  end

  eic_alu u_alu (
    .op(alu_op),
    .a(alu_a),
    .w(w_reg),
    .c_in(c_reg),
    .y(alu_y),
    .c_out(alu_c),
    .dc_out(alu_dc),
    .upd_c(upd_c),
    .upd_dc(upd_dc),
    .upd_z(upd_z)
  );

  // Execute: routing, flow change and cycle count of the instruction
  always_comb begin
    pc_inc = pc_reg + PC_W'(1);
    pc_n = pc_inc;
    wr_f = 1'b0;
    wr_w = 1'b0;
    f_new = alu_y;
    w_new = alu_y;
    two = 1'b0;
    skip = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    ptr_step = 1'b0;
    set_gie = 1'b0;
    do_sleep = 1'b0;
    do_wdt = 1'b0;
    unique case (cls)
      CLS_BYTE: begin
        wr_f = dsel || (op == OP_MOVWF);
        wr_w = !wr_f;
        if ((op == OP_DECSZ) || (op == OP_INCSZ)) begin
          two = 1'b1;
          skip = (alu_y == 8'h00);
        end
      end
      CLS_BIT: begin
        unique case (bop)
          BOP_CLEAR: begin
            wr_f = 1'b1;
            f_new = fval & ~bmask;
          end
          BOP_SET: begin
            wr_f = 1'b1;
            f_new = fval | bmask;
          end
          BOP_SKIP_CLR: begin
            two = 1'b1;
            skip = !bit_val;
          end
          BOP_SKIP_SET: begin
            two = 1'b1;
            skip = bit_val;
          end
        endcase
      end
      CLS_LIT: begin
        if (!cur[CLS_LO]) begin
          two = 1'b1;
          push = !cur[JMP_SEL];
          pc_n = {pc_reg[PC_W-1:K11_HI+1], cur[K11_HI:0]};
        end else begin
          case (op)
            LIT_LOADW: begin
              wr_w = 1'b1;
              w_new = k8;
            end
            LIT_ADDW, LIT_ANDW, LIT_XORW: wr_w = 1'b1;
            LIT_EXIT, LIT_RETURN, LIT_IEXIT: begin
              two = 1'b1;
              pop = 1'b1;
              pc_n = stack[sp_reg - SPW'(1)];
              wr_w = (op == LIT_EXIT);
              w_new = k8;
              set_gie = (op == LIT_IEXIT);
            end
            LIT_RELJMP: begin
              two = 1'b1;
              pc_n = pc_inc + PC_W'(signed'(k8));
            end
            LIT_ACCJMP: begin
              two = 1'b1;
              pc_n = pc_inc + PC_W'(w_reg);
            end
            LIT_ACCCALL: begin
              two = 1'b1;
              push = 1'b1;
              pc_n = {pc_reg[PC_W-1:8], w_reg};
            end
            LIT_PTR_RD: begin
              wr_w = 1'b1;
              w_new = fval;
              ptr_step = 1'b1;
            end
            LIT_PTR_WR: begin
              wr_f = 1'b1;
              f_new = w_reg;
              ptr_step = 1'b1;
            end
            LIT_SLEEP: do_sleep = 1'b1;
            LIT_WDTCLR: do_wdt = 1'b1;
            default: ;
          endcase
        end
      end
    endcase
    if (skip) begin
      pc_n = pc_inc + PC_W'(1);
    end
  end

  assign exec = cyc_end && (((state_reg == ST_EXEC) && !to_pmem) || (state_reg == ST_PMEM));

  // Sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_EXEC;
      ir_reg <= '0;
      pc_reg <= '0;
      pmem_addr <= '0;
    end else if (cyc_end) begin
      unique case (state_reg)
        ST_EXEC: begin
          if (to_pmem) begin
            state_reg <= ST_PMEM;
            ir_reg <= cur;
            pmem_addr <= ia[PC_W-1:0];
          end else begin
            state_reg <= two ? ST_FLUSH : ST_EXEC;
            pc_reg <= pc_n;
            pmem_addr <= pc_n;
          end
        end
        ST_PMEM: begin
          state_reg <= two ? ST_FLUSH : ST_EXEC;
          pc_reg <= pc_n;
          pmem_addr <= pc_n;
        end
        ST_FLUSH: state_reg <= ST_EXEC;
      endcase
    end
  end

  // Call stack; depth overflow wraps and overwrites the oldest entry
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sp_reg <= '0;
    end else if (exec && push) begin
      stack[sp_reg] <= pc_inc;
      sp_reg <= sp_reg + SPW'(1);
    end else if (exec && pop) begin
      sp_reg <= sp_reg - SPW'(1);
    end
  end

  // Write-back; program memory is never written
  always_ff @(posedge pclk) begin
    if (exec && wr_f && !to_pmem && (tgt > FA_WREG)) begin
      mem[tgt] <= f_new;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      w_reg <= 8'h00;
      c_reg <= 1'b0;
      dc_reg <= 1'b0;
      z_reg <= 1'b0;
    end else if (exec) begin
      if (wr_w) begin
        w_reg <= w_new;
      end else if (wr_f && !to_pmem && (tgt == FA_WREG)) begin
        w_reg <= f_new;
      end
      // Byte and bit operations drop a direct store to the status byte; only their ALU flag updates apply
      if (alu_used) begin
        c_reg <= upd_c ? alu_c : c_reg;
        dc_reg <= upd_dc ? alu_dc : dc_reg;
        z_reg <= upd_z ? (alu_y == 8'h00) : z_reg;
      end else if (wr_f && !to_pmem && (tgt == FA_STATUS)) begin
        c_reg <= f_new[ST_C];
        dc_reg <= f_new[ST_DC];
        z_reg <= f_new[ST_Z];
      end
    end
  end

  // Expiry and sleep flags are read-only to file writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_reg <= 1'b1;
      wdt_reg <= 1'b1;
    end else if (exec && (do_sleep || do_wdt)) begin
      sleep_reg <= do_wdt;
      wdt_reg <= 1'b1;
    end
  end

  for (genvar i = 0; i < 2; i++) begin : g_ptr
    logic wr_here;
    assign wr_here = exec && wr_f && !to_pmem;
    eic_ptr u_ptr (
      .pclk(pclk),
      .presetn(presetn),
      .ld_lo(wr_here && (tgt == (i == 0 ? FA_PTR0_LO : FA_PTR1_LO))),
      .ld_hi(wr_here && (tgt == (i == 0 ? FA_PTR0_HI : FA_PTR1_HI))),
      .wdata(f_new),
      .step(exec && ptr_step && (sel_n == 1'(i))),
      .mode(mm),
      .ptr_reg(p_val[i]),
      .eff(p_eff[i])
    );
  end

  // Observation counters
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cyc_cnt_reg <= '0;
      ret_cnt_reg <= '0;
      rd_cnt_reg <= '0;
      last_ir_reg <= '0;
    end else begin
      cyc_cnt_reg <= cyc_cnt_reg + {31'h0, cyc_end};
      ret_cnt_reg <= ret_cnt_reg + {31'h0, exec};
      rd_cnt_reg <= rd_cnt_reg + {31'h0, exec && (!lit || ptr_op)};
      if (exec) begin
        last_ir_reg <= cur;
      end
    end
  end

  // APB slave: one wait state, write lands at the completing edge
  logic apb_acc, apb_wr;
  assign apb_acc = psel && penable && !pready;
  assign apb_wr = psel && penable && pready && pwrite && (paddr == A_CTRL);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_reg <= 1'b0;
      gie_reg <= 1'b0;
    end else begin
      if (apb_wr) begin
        run_reg <= pwdata[CTRL_RUN];
      end
      // Hardware set beats a simultaneous software clear
      if (exec && set_gie) begin
        gie_reg <= 1'b1;
      end else if (apb_wr) begin
        gie_reg <= pwdata[CTRL_GIE];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= apb_acc;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      if (apb_acc) begin
        unique case (paddr)
          A_CTRL: prdata <= {30'h0, gie_reg, run_reg};
          A_STATUS: prdata <= {13'h0, state_reg, 6'h0, q_reg, status_byte};
          A_WREG: prdata <= {24'h0, w_reg};
          A_PC: prdata <= {(PC_SP_LO - SPW)'(0), sp_reg, 1'b0, pc_reg};
          A_IR: prdata <= {18'h0, last_ir_reg};
          A_CYCLES: prdata <= cyc_cnt_reg;
          A_RETIRED: prdata <= ret_cnt_reg;
          A_READS: prdata <= rd_cnt_reg;
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end
endmodule // eic_core
`default_nettype wire

// ### eic_core_chk.sv
`default_nettype none
module eic_core_chk import eic_pkg::*; (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Program memory
  input wire logic [PC_W-1:0] pmem_addr,
  input wire logic [INSTR_W-1:0] pmem_rdata
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_ready_wait: assert property (psel && penable && !pready |=> pready)
    else $error("pready missing after one wait state");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  chk_ready_cause: assert property (pready |-> $past(psel && penable))
    else $error("pready without an access phase");
  chk_err_pair: assert property (pslverr |-> pready)
    else $error("pslverr outside a completion");
  chk_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero while idle");
  chk_err_unmapped: assert property (pready && paddr[1:0] == 2'h0 |-> pslverr == (paddr > A_READS))
    else $error("pslverr does not match the address map");
  chk_fetch_hold: assert property (
    $changed(pmem_addr) |=> $stable(pmem_addr) [*3])
    else $error("fetch address held under four clocks");
  chk_jump_flush: assert property (
    $changed(pmem_addr) && $past(pmem_rdata[13:12]) == 2'b10
      |-> pmem_addr[10:0] == $past(pmem_rdata[10:0]) ##1 $stable(pmem_addr) [*7])
    else $error("jump or call without target and flush cycle");
  chk_one_cycle: assert property (
    $changed(pmem_addr) && $past(pmem_rdata[13:8]) == 6'h30
      |-> pmem_addr == $past(pmem_addr) + 15'h1 ##1 $stable(pmem_addr) [*3]
      ##1 $changed(pmem_addr))
    else $error("literal load not a single instruction cycle");
endmodule // eic_core_chk
`default_nettype wire

// ### eic_pmem_model.sv
`default_nettype none
module eic_pmem_model import eic_pkg::*; (
  // Clock
  input wire logic pclk,
  // Latency select
  input wire logic slow,
  // Fetch port
  input wire logic [PC_W-1:0] pmem_addr,
  output logic [INSTR_W-1:0] pmem_rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [INSTR_W-1:0] mem [0:255];
  logic [INSTR_W-1:0] late_reg;

  // Slow mode answers one clock late, inside the allowed three-clock latency
  always_ff @(posedge pclk) begin
    late_reg <= mem[pmem_addr[7:0]];
  end
  assign pmem_rdata = slow ? late_reg : mem[pmem_addr[7:0]];
endmodule // eic_pmem_model
`default_nettype wire

// ### test_eic_core.sv
`default_nettype none
module test_eic_core import eic_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int NT = 17;
  localparam int EXP_A [NT] = '{1, 2, 3, 4, 6, 8, 12, 13, 14, 15, 16, 32, 17, 18, 33, 19, 9};
  localparam int EXP_D [NT] = '{4, 4, 4, 4, 8, 8, 8, 4, 4, 4, 4, 4, 4, 4, 4, 4, 8};
  // Word 18 is a pre-increment pointer read with its unused literal bits set on purpose
  localparam logic [INSTR_W-1:0] PROG [20] = '{14'h3005, 14'h008a, 14'h0a0a, 14'h178a,
    14'h1f8a, 14'h30ee, 14'h2808, 14'h30ff, 14'h200c, 14'h070b, 14'h280a, 14'h0000,
    14'h3080, 14'h0085, 14'h3020, 14'h0084, 14'h0800, 14'h008b, 14'h36f8, 14'h345c};
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er, slow;
  logic [APB_AW-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [PC_W-1:0] pmem_addr, last_addr;
  logic [INSTR_W-1:0] pmem_rdata;
  logic [PC_W-1:0] taddr [$];
  int tdwell [$];
  int n_mismatch = 0;
  int checked = 0;
  int dwell;
  int n;
  bit seen;

  eic_core i_eic_core (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pmem_addr(pmem_addr), .pmem_rdata(pmem_rdata));
  eic_pmem_model i_eic_pmem_model (.pclk(pclk), .slow(slow), .pmem_addr(pmem_addr),
    .pmem_rdata(pmem_rdata));

  always #12.5 pclk = ~pclk;

  // Log each fetch address with the clocks it was held; the idle address before run is dropped
  always @(posedge pclk) begin
    if (!presetn) begin
      seen = 0;
      last_addr = '0;
      dwell = 0;
      taddr.delete();
      tdwell.delete();
    end else if (pmem_addr !== last_addr) begin
      if (seen) begin
        taddr.push_back(last_addr);
        tdwell.push_back(dwell);
      end
      seen = 1;
      last_addr = pmem_addr;
      dwell = 1;
    end else begin
      dwell++;
    end
  end

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] seen_v);
    checked++;
    if (seen_v !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", name, exp, seen_v);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for a slave that never answers
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic end_of_test();
    if (n_mismatch == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge pclk);
    n_mismatch++;
    end_of_test();
  end

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    slow = 1'b0;
    for (int i = 0; i < 256; i++) i_eic_pmem_model.mem[i] = (i < 20) ? PROG[i] : 14'h0000;
    i_eic_pmem_model.mem[32] = 14'h3a5b;
    // Second pass repeats the program with a slow memory after a fresh reset
    for (int p = 0; p < 2; p++) begin
      presetn <= 1'b0;
      slow <= p[0];
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, A_STATUS, 32'h0);
      check("status", 32'h00010018, rd);
      apb(1'b0, 8'h20, 32'h0);
      check("unmapped", 32'h1, {31'h0, er});
      apb(1'b1, A_WREG, 32'h77);
      apb(1'b0, A_WREG, 32'h0);
      check("w reset", 32'h0, rd);
      apb(1'b1, A_CTRL, 32'h1);
      n = 0;
      do begin
        apb(1'b0, A_PC, 32'h0);
        n++;
      end while (rd[14:0] !== 15'h00a && n < 100);
      check("pc reached", 32'h0000000a, {17'h0, rd[14:0]});
      apb(1'b1, A_CTRL, 32'h0);
      apb(1'b0, A_WREG, 32'h0);
      check("w result", 32'h000000b7, rd);
      apb(1'b0, A_STATUS, 32'h0);
      check("flags", 32'h0000001a, {24'h0, rd[7:0]});
      apb(1'b0, A_READS, 32'h0);
      check("file reads", 32'h0000000a, rd);
      check("trace length", 32'(NT), 32'(taddr.size()));
      for (int i = 0; i < NT && i < taddr.size(); i++) begin
        check("fetch addr", 32'(EXP_A[i]), 32'(taddr[i]));
        check("fetch dwell", 32'(EXP_D[i]), 32'(tdwell[i]));
      end
    end
    end_of_test();
  end
endmodule // test_eic_core

bind eic_core eic_core_chk i_eic_core_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .pmem_addr(pmem_addr), .pmem_rdata(pmem_rdata));
`default_nettype wire
